// ### inc/buck_two_params.svh
// constants for the buck two configuration register bank
`ifndef BUCK_TWO_PARAMS_SVH
`define BUCK_TWO_PARAMS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_NORMAL   8'h35
`define ADDR_STANDBY  8'h36
`define ADDR_SLEEP    8'h37
`define ADDR_MODE     8'h38
`define ADDR_CONF     8'h39

// ****************************************************************
// field positions
// ****************************************************************
`define SP_MSB           5
`define SP_LSB           0
`define RANGE_BIT        6
`define MODE_MSB         3
`define MODE_LSB         0
`define SLEEP_STATE_BIT  5
`define ILIM_BIT         0
`define FREQ_MSB         3
`define FREQ_LSB         2
`define PHASE_MSB        5
`define PHASE_LSB        4
`define DVS_MSB          7
`define DVS_LSB          6

// ****************************************************************
// reset values
// ****************************************************************
`define RST_SETPOINT  6'h00
`define RST_RANGE     1'b0
`define RST_MODE_REG  8'h80
`define RST_SLEEP_ST  1'b0
`define RST_CONF      8'h00
`define RD_ZERO       8'h00

`endif

// ### inc/buck_two_pkg.sv
// types shared by the buck two configuration register bank
package buck_two_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] setpoint_t;
  typedef logic [3:0] mode_t;
  typedef logic [1:0] sel2_t;

  // register selected by an access address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_NORMAL,
    SEL_STANDBY,
    SEL_SLEEP,
    SEL_MODE,
    SEL_CONF
  } reg_sel_t;

endpackage : buck_two_pkg

// ### design/setpoint_field.sv
// one six bit read/write voltage set point field
`timescale 1ns/100ps
`include "buck_two_params.svh"

module setpoint_field (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              wr_en_in,
  input  wire buck_two_pkg::setpoint_t wdata_in,
  output buck_two_pkg::setpoint_t      value_out
);
  import buck_two_pkg::*;

  setpoint_t value_q;
  setpoint_t value_d;

  // ****************************************************************
  // set point storage
  // ****************************************************************

  // load on a host write, hold otherwise
  always_comb begin
    value_d = value_q;
    if (wr_en_in) begin
      value_d = wdata_in;
    end
  end

  // register, cleared by reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      value_q <= `RST_SETPOINT;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_out = value_q;

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // a write lands one cycle after its strobe
  property p_sp_load;
    wr_en_in |=> value_out == $past(wdata_in);
  endproperty
  a_sp_load: assert property (p_sp_load)
    else $error("set point not loaded by write");

  // writes to other registers never disturb this one
  property p_sp_hold;
    !wr_en_in |=> $stable(value_out);
  endproperty
  a_sp_hold: assert property (p_sp_hold)
    else $error("set point moved without a write");

endmodule : setpoint_field

// ### design/switching_config.sv
// switching configuration byte: limit, frequency, phase, speed
`timescale 1ns/100ps
`include "buck_two_params.svh"

module switching_config (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              wr_en_in,
  input  wire buck_two_pkg::reg_byte_t wdata_in,
  output buck_two_pkg::reg_byte_t      conf_out,
  output logic                   current_limit_select_out,
  output buck_two_pkg::sel2_t    frequency_select_out,
  output buck_two_pkg::sel2_t    phase_clock_select_out,
  output buck_two_pkg::sel2_t    voltage_scaling_speed_out
);
  import buck_two_pkg::*;

  reg_byte_t conf_q;
  reg_byte_t conf_d;

  // ****************************************************************
  // configuration storage
  // ****************************************************************

  // every bit is read/write, the spare bit included
  always_comb begin
    conf_d = conf_q;
    if (wr_en_in) begin
      conf_d = wdata_in;
    end
  end

  // register, cleared by reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conf_q <= `RST_CONF;
    end else begin
      conf_q <= conf_d;
    end
  end

  // field taps toward the regulator
  assign conf_out                  = conf_q;
  assign current_limit_select_out  = conf_q[`ILIM_BIT];
  assign frequency_select_out      = conf_q[`FREQ_MSB:`FREQ_LSB];
  assign phase_clock_select_out    = conf_q[`PHASE_MSB:`PHASE_LSB];
  assign voltage_scaling_speed_out = conf_q[`DVS_MSB:`DVS_LSB];

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_ilim_wr;
    wr_en_in |=> current_limit_select_out == $past(wdata_in[`ILIM_BIT]);
  endproperty
  a_ilim_wr: assert property (p_ilim_wr)
    else $error("current limit bit not loaded by write");

  property p_conf_fields;
    wr_en_in |=> {voltage_scaling_speed_out, phase_clock_select_out,
      frequency_select_out} == $past(wdata_in[`DVS_MSB:`FREQ_LSB]);
  endproperty
  a_conf_fields: assert property (p_conf_fields)
    else $error("configuration fields not loaded by write");

  // writes to other registers never disturb the byte
  property p_conf_hold;
    !wr_en_in |=> $stable(conf_out);
  endproperty
  a_conf_hold: assert property (p_conf_hold)
    else $error("configuration moved without a write");

endmodule : switching_config

// ### design/buck_two_config_registers.sv
// register bank controlling the second buck regulator
//
// Behaviour
// - the bank offers five byte registers at 0x35 to 0x39 to the host.
// - bits 5:0 of the normal register hold the normal set point, reset 0.
// - bit 6 of the normal register is the range bit, loaded only by config.
// - bits 5:0 of the standby register hold the standby set point, reset 0.
// - bit 6 of the standby register reads back the configured range bit.
// - bits 5:0 of the sleep register hold the sleep set point, reset 0.
// - bit 6 of the sleep register reads back the configured range bit.
// - bits 3:0 of the mode register pick the switching mode.
// - bit 5 of the mode register chooses off or pulse mode in sleep.
// - bit 0 of the config register picks high (0) or low (1) limit.
// - bits 3:2 of the config register pick the switching frequency.
// - bits 5:4 of the config register pick the phase clock.
// - bits 7:6 of the config register pick the voltage scaling speed.
`timescale 1ns/100ps
`include "buck_two_params.svh"

module buck_two_config_registers (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  // register access from the serial bus engine
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  input  wire buck_two_pkg::reg_byte_t reg_wdata_in,
  output buck_two_pkg::reg_byte_t      reg_rdata_out,
  output logic                         reg_rvalid_out,
  // range bit from one time or prototype configuration
  input  wire logic                    cfg_load_in,
  input  wire logic                    cfg_range_in,
  // controls toward the regulator
  output buck_two_pkg::setpoint_t      normal_setpoint_out,
  output buck_two_pkg::setpoint_t      standby_setpoint_out,
  output buck_two_pkg::setpoint_t      sleep_setpoint_out,
  output logic                         range_select_out,
  output buck_two_pkg::mode_t          switching_mode_out,
  output logic                         sleep_state_select_out,
  output logic                         current_limit_select_out,
  output buck_two_pkg::sel2_t          frequency_select_out,
  output buck_two_pkg::sel2_t          phase_clock_select_out,
  output buck_two_pkg::sel2_t          voltage_scaling_speed_out
);
  import buck_two_pkg::*;

  // full reset byte of the mode register; only the mode field is kept
  localparam reg_byte_t MODE_RST = `RST_MODE_REG;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // map an access address onto the register it selects
  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    reg_sel_t sel;
    case (addr)
      `ADDR_NORMAL:  sel = SEL_NORMAL;
      `ADDR_STANDBY: sel = SEL_STANDBY;
      `ADDR_SLEEP:   sel = SEL_SLEEP;
      `ADDR_MODE:    sel = SEL_MODE;
      `ADDR_CONF:    sel = SEL_CONF;
      default:       sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // read byte of a voltage register: set point plus range bit
  function automatic reg_byte_t sp_byte(input logic      range,
                                        input setpoint_t sp);
    reg_byte_t b;
    b = `RD_ZERO;
    b[`SP_MSB:`SP_LSB] = sp;
    b[`RANGE_BIT] = range;
    return b;
  endfunction : sp_byte

  // ****************************************************************
  // decode
  // ****************************************************************

  reg_sel_t  wr_sel;
  reg_sel_t  rd_sel;
  setpoint_t wr_sp;
  logic      wr_normal;
  logic      wr_standby;
  logic      wr_sleep;
  logic      wr_conf;
  reg_byte_t conf_byte;

  // write strobes per register; unmapped writes hit nothing
  assign wr_sel     = decode_addr(reg_addr_in);
  assign rd_sel     = decode_addr(reg_addr_in);
  assign wr_sp      = reg_wdata_in[`SP_MSB:`SP_LSB];
  assign wr_normal  = reg_wr_in && (wr_sel == SEL_NORMAL);
  assign wr_standby = reg_wr_in && (wr_sel == SEL_STANDBY);
  assign wr_sleep   = reg_wr_in && (wr_sel == SEL_SLEEP);
  assign wr_conf    = reg_wr_in && (wr_sel == SEL_CONF);

  // ****************************************************************
  // set point registers
  // ****************************************************************

  // normal operation set point
  setpoint_field u_normal (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (wr_normal),
    .wdata_in   (wr_sp),
    .value_out  (normal_setpoint_out)
  );

  // standby set point
  setpoint_field u_standby (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (wr_standby),
    .wdata_in   (wr_sp),
    .value_out  (standby_setpoint_out)
  );

  // sleep set point
  setpoint_field u_sleep (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (wr_sleep),
    .wdata_in   (wr_sp),
    .value_out  (sleep_setpoint_out)
  );

  // ****************************************************************
  // range bit
  // ****************************************************************

  logic range_q;
  logic range_d;

  // only the configuration load moves it; host writes never do
  always_comb begin
    range_d = range_q;
    if (cfg_load_in) begin
      range_d = cfg_range_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      range_q <= `RST_RANGE;
    end else begin
      range_q <= range_d;
    end
  end

  assign range_select_out = range_q;

  // ****************************************************************
  // mode register
  // ****************************************************************

  mode_t mode_q;
  mode_t mode_d;
  logic  sleep_st_q;
  logic  sleep_st_d;

  // only the mode field and the sleep state bit are stored
  always_comb begin
    mode_d     = mode_q;
    sleep_st_d = sleep_st_q;
    if (reg_wr_in && (wr_sel == SEL_MODE)) begin
      mode_d     = reg_wdata_in[`MODE_MSB:`MODE_LSB];
      sleep_st_d = reg_wdata_in[`SLEEP_STATE_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_q     <= MODE_RST[`MODE_MSB:`MODE_LSB];
      sleep_st_q <= `RST_SLEEP_ST;
    end else begin
      mode_q     <= mode_d;
      sleep_st_q <= sleep_st_d;
    end
  end

  assign switching_mode_out     = mode_q;
  assign sleep_state_select_out = sleep_st_q;

  // ****************************************************************
  // configuration register
  // ****************************************************************

  switching_config u_conf (
    .clk_in                    (clk_in),
    .sys_rst_in                (sys_rst_in),
    .wr_en_in                  (wr_conf),
    .wdata_in                  (reg_wdata_in),
    .conf_out                  (conf_byte),
    .current_limit_select_out  (current_limit_select_out),
    .frequency_select_out      (frequency_select_out),
    .phase_clock_select_out    (phase_clock_select_out),
    .voltage_scaling_speed_out (voltage_scaling_speed_out)
  );

  // ****************************************************************
  // read path
  // ****************************************************************

  reg_byte_t rdata_q;
  reg_byte_t rdata_d;
  logic      rvalid_q;
  logic      rvalid_d;

  // read byte one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd_in;
    if (reg_rd_in) begin
      case (rd_sel)
        SEL_NORMAL: begin
          rdata_d = sp_byte(range_q, normal_setpoint_out);
        end
        SEL_STANDBY: begin
          rdata_d = sp_byte(range_q, standby_setpoint_out);
        end
        SEL_SLEEP: begin
          rdata_d = sp_byte(range_q, sleep_setpoint_out);
        end
        SEL_MODE: begin
          rdata_d = `RD_ZERO;
          rdata_d[`MODE_MSB:`MODE_LSB] = mode_q;
          rdata_d[`SLEEP_STATE_BIT]    = sleep_st_q;
        end
        SEL_CONF: begin
          rdata_d = conf_byte;
        end
        default: begin
          rdata_d = `RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q  <= `RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_out  = rdata_q;
  assign reg_rvalid_out = rvalid_q;

  // ****************************************************************
  // checks
  // ****************************************************************

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // a write or read strobe aimed at one address
  sequence s_wr(logic [7:0] a);
    reg_wr_in && (reg_addr_in == a);
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_in && (reg_addr_in == a);
  endsequence

  property p_rd_answer;
    reg_rd_in |=> reg_rvalid_out ##1 (reg_rvalid_out == $past(reg_rd_in));
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer not one cycle after strobe");

  property p_range_ro;
    (!cfg_load_in && reg_wr_in) |=> $stable(range_q);
  endproperty
  a_range_ro: assert property (p_range_ro)
    else $error("range bit moved without configuration load");

  property p_standby_range;
    s_rd(`ADDR_STANDBY) ##0 !cfg_load_in |=>
      reg_rdata_out[`RANGE_BIT] == range_q;
  endproperty
  a_standby_range: assert property (p_standby_range)
    else $error("standby range bit does not mirror configuration");

  property p_sleep_range;
    s_rd(`ADDR_SLEEP) ##0 !cfg_load_in |=>
      reg_rdata_out[`RANGE_BIT] == range_q;
  endproperty
  a_sleep_range: assert property (p_sleep_range)
    else $error("sleep range bit does not mirror configuration");

  property p_mode_wr;
    s_wr(`ADDR_MODE) |=> switching_mode_out ==
      $past(reg_wdata_in[`MODE_MSB:`MODE_LSB]);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode field not loaded by write");

  property p_sleep_state;
    s_wr(`ADDR_MODE) |=> sleep_state_select_out ==
      $past(reg_wdata_in[`SLEEP_STATE_BIT]);
  endproperty
  a_sleep_state: assert property (p_sleep_state)
    else $error("sleep state bit not loaded by write");

  property p_mode_unused;
    s_rd(`ADDR_MODE) |=> reg_rvalid_out &&
      (reg_rdata_out[7:6] == 2'h0) && !reg_rdata_out[4];
  endproperty
  a_mode_unused: assert property (p_mode_unused)
    else $error("unused mode bits read nonzero");

  property p_volt_unused;
    (s_rd(`ADDR_NORMAL) or s_rd(`ADDR_STANDBY) or s_rd(`ADDR_SLEEP)) |=>
      !reg_rdata_out[7];
  endproperty
  a_volt_unused: assert property (p_volt_unused)
    else $error("unused voltage bit reads nonzero");

endmodule : buck_two_config_registers

// ### tb/host_model.sv
// host-side model that issues byte reads and writes to the register bank
`timescale 1ns/100ps

module host_model (
  input  wire logic                    clk_in,
  output buck_two_pkg::reg_byte_t      addr_out,
  output logic                         wr_out,
  output logic                         rd_out,
  output buck_two_pkg::reg_byte_t      wdata_out,
  input  wire buck_two_pkg::reg_byte_t rdata_in,
  input  wire logic                    rvalid_in
);
  import buck_two_pkg::*;

  // ****************
  // bus idle state
  // ****************
  initial begin
    addr_out  = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    wdata_out = 8'h00;
  end

  // one strobe after gap idle cycles; answer is taken one cycle later
  task automatic access(input reg_byte_t a, input reg_byte_t d,
                        input logic w, input logic r,
                        input logic [1:0] gap,
                        output reg_byte_t q, output logic v);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= w;
    rd_out    <= r;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    addr_out  <= ~a;  // released lines never keep the last value
    wdata_out <= ~d;
    #1;
    q = rdata_in;
    v = rvalid_in;
  endtask : access

endmodule : host_model

// ### tb/test_buck_two_config_registers.sv
// self-checking bench for the buck two configuration register bank
`timescale 1ns/100ps
`include "buck_two_params.svh"

module test_buck_two_config_registers;
  import buck_two_pkg::*;

  // ****************
  // clock, wiring and expected state
  // ****************
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        cfg_load_in = 1'b0;
  logic        cfg_range_in = 1'b0;
  reg_byte_t   reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic        reg_wr_in, reg_rd_in, reg_rvalid_out, range_select_out;
  logic        sleep_state_select_out, current_limit_select_out;
  setpoint_t   normal_setpoint_out, standby_setpoint_out;
  setpoint_t   sleep_setpoint_out;
  mode_t       switching_mode_out;
  sel2_t       frequency_select_out, phase_clock_select_out;
  sel2_t       voltage_scaling_speed_out;
  int          errors = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h2a47;
  setpoint_t   sp_e [3];
  logic        rng_e, slp_e;
  mode_t       mode_e;
  reg_byte_t   conf_e;

  // 125 MHz clock
  always #4 clk_in = ~clk_in;

  host_model host (
    .clk_in    (clk_in),
    .addr_out  (reg_addr_in),
    .wr_out    (reg_wr_in),
    .rd_out    (reg_rd_in),
    .wdata_out (reg_wdata_in),
    .rdata_in  (reg_rdata_out),
    .rvalid_in (reg_rvalid_out)
  );

  buck_two_config_registers dut (
    .clk_in, .sys_rst_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
    .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .cfg_load_in,
    .cfg_range_in, .normal_setpoint_out, .standby_setpoint_out,
    .sleep_setpoint_out, .range_select_out, .switching_mode_out,
    .sleep_state_select_out, .current_limit_select_out,
    .frequency_select_out, .phase_clock_select_out,
    .voltage_scaling_speed_out
  );

  // ****************
  // reference model and checks
  // ****************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // byte a read at address a should return
  function automatic reg_byte_t exp_read(input reg_byte_t a);
    case (a)
      `ADDR_NORMAL:  return {1'b0, rng_e, sp_e[0]};
      `ADDR_STANDBY: return {1'b0, rng_e, sp_e[1]};
      `ADDR_SLEEP:   return {1'b0, rng_e, sp_e[2]};
      `ADDR_MODE:    return {2'b00, slp_e, 1'b0, mode_e};
      `ADDR_CONF:    return conf_e;
      default:       return 8'h00;
    endcase
  endfunction : exp_read

  // only writable bits change the model
  task automatic apply_write(input reg_byte_t a, input reg_byte_t d);
    case (a)
      `ADDR_NORMAL:  sp_e[0] = d[5:0];
      `ADDR_STANDBY: sp_e[1] = d[5:0];
      `ADDR_SLEEP:   sp_e[2] = d[5:0];
      `ADDR_MODE: begin
        mode_e = d[3:0];
        slp_e  = d[5];
      end
      `ADDR_CONF:    conf_e = d;
      default:       ;
    endcase
  endtask : apply_write

  task automatic check_read(input logic [8:0] e, input logic [8:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check_read

  // all control outputs packed against the model
  task automatic check_outs();
    logic [30:0] e;
    logic [30:0] g;
    e = {sp_e[0], sp_e[1], sp_e[2], rng_e, mode_e, slp_e, conf_e[7:2],
         conf_e[0]};
    g = {normal_setpoint_out, standby_setpoint_out, sleep_setpoint_out,
         range_select_out, switching_mode_out, sleep_state_select_out,
         voltage_scaling_speed_out, phase_clock_select_out,
         frequency_select_out, current_limit_select_out};
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check_outs

  // one host access, then read data and outputs are compared
  task automatic do_access(input reg_byte_t a, input reg_byte_t d,
                           input logic w, input logic r);
    reg_byte_t  q;
    logic       v;
    logic [8:0] e;
    e = {r, r ? exp_read(a) : 8'h00};
    if (w) begin
      apply_write(a, d);
    end
    host.access(a, d, w, r, 2'(rnd() % 3), q, v);
    check_read(e, {v, r ? q : 8'h00});
    check_outs();
  endtask : do_access

  task automatic load_range(input logic b);
    @(posedge clk_in);
    cfg_load_in  <= 1'b1;
    cfg_range_in <= b;
    @(posedge clk_in);
    cfg_load_in  <= 1'b0;
    cfg_range_in <= ~b;  // ignored while no load strobe
    rng_e = b;
    #1;
    check_outs();
  endtask : load_range

  task automatic do_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    sp_e   = '{default: 6'h00};
    rng_e  = 1'b0;
    slp_e  = 1'b0;
    mode_e = 4'h0;
    conf_e = 8'h00;
    repeat (20) @(posedge clk_in);
    check_outs();
    sys_rst_in <= 1'b0;
  endtask : do_reset

  task automatic final_report();
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge clk_in);
    errors++;
    final_report();
  end

  // corner cases, exhaustive field codes, random traffic, mid-run reset
  initial begin
    logic [31:0] r;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      do_access(8'h35 + 8'(i), 8'h00, 1'b0, 1'b1);
    end
    load_range(1'b1);
    for (int i = 0; i < 7; i++) begin
      do_access(8'h34 + 8'(i), 8'hff, 1'b1, 1'b0);
      do_access(8'h34 + 8'(i), 8'h00, 1'b0, 1'b1);
      do_access(8'h34 + 8'(i), 8'h00, 1'b1, 1'b1);
      do_access(8'h34 + 8'(i), 8'h00, 1'b0, 1'b1);
    end
    for (int i = 0; i < 16; i++) begin
      do_access(`ADDR_MODE, {3'b111, 1'b1, 4'(i)}, 1'b1, 1'b1);
      do_access(`ADDR_MODE, {2'b00, i[0], 1'b0, 4'(i)}, 1'b1, 1'b1);
      do_access(`ADDR_CONF, {4'(i), 4'(i)}, 1'b1, 1'b1);
    end
    load_range(1'b0);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      if (r[31:28] == 4'h0) begin
        load_range(r[0]);
      end else begin
        do_access(8'h33 + (r[7:0] % 8'd9), r[15:8], r[16], r[17]);
      end
    end
    do_reset();
    do_access(`ADDR_NORMAL, 8'h00, 1'b0, 1'b1);
    final_report();
  end

endmodule : test_buck_two_config_registers
